// [core/lcf_unit.v]
// Purpose: Lookup table function unit of a programmable logic cell
// Assumes: Configuration held by the caller as plain ports
// Notes: Table is clocked storage here; memory writes take effect
// Notes: on the edge while the gated enable is high
`timescale 1ns/100ps
`include "lcf_consts.vh"

module lcf_unit
(
	// Clock and control
	input wire sys_clk,
	input wire rst,
	input wire clk_en,
	// Configuration
	input wire [`LCF_MODE_W-1:0] half_mode_upper,
	input wire [`LCF_MODE_W-1:0] half_mode_lower,
	input wire [1:0] combine_sel,
	input wire [1:0] ripple_submode,
	input wire [1:0] ripple_in_sel,
	input wire [1:0] ripple_out_port_route,
	input wire wpe_from_ripple_in,
	input wire read_to_storage,
	input wire cfg_load,
	input wire [`LCF_TABLE_BITS-1:0] cfg_table,
	// Cell inputs
	input wire [4:0] first_bus,
	input wire [4:0] second_bus,
	input wire bypass_control_input,
	input wire fast_carry_in,
	input wire [3:0] direct_write_bits,
	// Cell outputs
	output reg quarter_out_zero,
	output reg combine_gate_out,
	output reg nand_gate_out,
	output reg quarter_out_three,
	output reg fifth_cell_output,
	output reg ripple_out_port,
	output reg [3:0] storage_data,
	output wire mode_error
);

	// ------------------------------------------------------------
	// Table storage
	// ------------------------------------------------------------
	reg [`LCF_TABLE_BITS-1:0] table_reg;
	reg [`LCF_TABLE_BITS-1:0] table_next;

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	wire ripple_on;
	wire mem_upper;
	wire mem_lower;
	wire mem_any;
	wire five_both;
	wire comb_ok;
	wire ripple_in_port;
	wire write_port_gate;
	wire we_upper;
	wire we_lower;

	// Ripple claims the whole table, halves may not differ
	assign ripple_on = (half_mode_upper == `LCF_MODE_RIPPLE) &&
		(half_mode_lower == `LCF_MODE_RIPPLE);
	assign mem_upper = !ripple_on &&
		(half_mode_upper == `LCF_MODE_MEMORY);
	assign mem_lower = !ripple_on &&
		(half_mode_lower == `LCF_MODE_MEMORY);
	assign mem_any = mem_upper || mem_lower;
	assign five_both = (half_mode_upper == `LCF_MODE_LOGIC) &&
		(half_mode_lower == `LCF_MODE_LOGIC);
	// Two-bit select cannot name both gates at once
	assign comb_ok = five_both &&
		(combine_sel != `LCF_COMB_NONE) &&
		(combine_sel != 2'h3);
	// Flag only, illegal settings are not blocked
	assign mode_error = ((half_mode_upper == `LCF_MODE_RIPPLE) !=
		(half_mode_lower == `LCF_MODE_RIPPLE)) ||
		((combine_sel != `LCF_COMB_NONE) && !comb_ok);

	// ------------------------------------------------------------
	// Ripple-in and write port gate
	// ------------------------------------------------------------
	assign ripple_in_port =
		(ripple_in_sel == `LCF_CIN_FAST) ? fast_carry_in :
		(ripple_in_sel == `LCF_CIN_BUS) ? second_bus[4] :
		(ripple_in_sel == `LCF_CIN_ONE) ? 1'b1 : 1'b0;
	// One gate serves both halves
	assign write_port_gate = wpe_from_ripple_in ? ripple_in_port :
		bypass_control_input;
	assign we_upper = mem_upper && first_bus[4] &&
		write_port_gate;
	assign we_lower = mem_lower && second_bus[4] &&
		write_port_gate;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function lut5;
		input [`LCF_HALF_BITS-1:0] half;
		input [4:0] sel;
		begin
			lut5 = half[sel];
		end
	endfunction

	function [1:0] mem_read;
		input [`LCF_HALF_BITS-1:0] half;
		input [3:0] addr;
		begin
			mem_read = {half[{1'b1, addr}], half[{1'b0, addr}]};
		end
	endfunction

	// Table bit of a word: quarter on top, word address below
	function [5:0] bit_index;
		input [1:0] quarter;
		input [3:0] addr;
		begin
			bit_index = {quarter, addr};
		end
	endfunction

	// ------------------------------------------------------------
	// Ripple cell
	// ------------------------------------------------------------
	// Compare mode keeps only the mismatch, carry-in is not summed
	function cell_sum;
		input a_bit;
		input b_bit;
		input c_bit;
		input cmp;
		begin
			if (cmp)
				cell_sum = a_bit ^ b_bit;
			else
				cell_sum = a_bit ^ b_bit ^ c_bit;
		end
	endfunction

	// Propagate when bits differ, else generate from a; compare mode ORs the mismatch into the carry
	function cell_carry;
		input a_bit;
		input b_bit;
		input c_bit;
		input cmp;
		begin
			if (cmp)
				cell_carry = c_bit | (a_bit ^ b_bit);
			else if (a_bit ^ b_bit)
				cell_carry = c_bit;
			else
				cell_carry = a_bit;
		end
	endfunction

	// ------------------------------------------------------------
	// Ripple datapath
	// ------------------------------------------------------------
	reg [3:0] op_a;
	reg [3:0] op_b;
	reg [3:0] sum_bits;
	reg [4:0] carry;
	reg carry_first;
	integer i;
	wire cmp_on;

	// Compare chain only collects mismatches, ripple-in is dropped
	assign cmp_on = (ripple_submode == `LCF_SUB_EQUAL);

	always @*
	begin
		op_a = first_bus[3:0];
		op_b = second_bus[3:0];
		carry_first = ripple_in_port;
		case (ripple_submode)
			`LCF_SUB_ADDSUB:
			begin
				// Subtract as a plus inverted b plus carry
				if (!first_bus[4])
					op_b = ~second_bus[3:0];
			end
			`LCF_SUB_COUNT:
			begin
				op_b = first_bus[4] ? `LCF_COUNT_STEP :
					~`LCF_COUNT_STEP;
				carry_first = !first_bus[4];
			end
			`LCF_SUB_MULT:
			begin
				op_b = first_bus[4] ? second_bus[3:0] : 4'h0;
			end
			`LCF_SUB_EQUAL:
			begin
				carry_first = 1'b0;
			end
			default:
			begin
				op_b = second_bus[3:0];
			end
		endcase
		carry[0] = carry_first;
		sum_bits = 4'h0;
		for (i = 0; i < 4; i = i + 1)
		begin
			sum_bits[i] = cell_sum(op_a[i], op_b[i], carry[i],
				cmp_on);
			carry[i + 1] = cell_carry(op_a[i], op_b[i], carry[i],
				cmp_on);
		end
	end

	// ------------------------------------------------------------
	// Output selection
	// ------------------------------------------------------------
	reg up_res;
	reg lo_res;
	reg [1:0] up_rd;
	reg [1:0] lo_rd;
	reg [3:0] quarter_vals;

	always @*
	begin
		up_res = lut5(table_reg[`LCF_TABLE_BITS-1:`LCF_HALF_BITS],
			first_bus);
		lo_res = lut5(table_reg[`LCF_HALF_BITS-1:0], second_bus);
		// Read data follows address with no clock
		up_rd = mem_read(table_reg[`LCF_TABLE_BITS-1:`LCF_HALF_BITS],
			first_bus[3:0]);
		lo_rd = mem_read(table_reg[`LCF_HALF_BITS-1:0],
			second_bus[3:0]);
		quarter_vals = 4'h0;
		quarter_out_zero = 1'b0;
		combine_gate_out = 1'b0;
		nand_gate_out = 1'b1;
		quarter_out_three = 1'b0;
		fifth_cell_output = 1'b0;
		ripple_out_port = 1'b0;
		if (ripple_on)
		begin
			quarter_vals = sum_bits;
			quarter_out_zero = sum_bits[0];
			combine_gate_out = sum_bits[1];
			nand_gate_out = sum_bits[2];
			quarter_out_three = sum_bits[3];
			ripple_out_port = ripple_out_port_route[`LCF_RIPPLE_OUT_PORT_FAST_BIT] &
				carry[4];
			fifth_cell_output = ripple_out_port_route[`LCF_RIPPLE_OUT_PORT_PIN_BIT] &
				carry[4];
		end
		else
		begin
			quarter_out_zero = mem_lower ? lo_rd[0] : lo_res;
			quarter_out_three = mem_upper ? up_rd[1] : up_res;
			if (mem_lower)
				combine_gate_out = lo_rd[1];
			if (mem_upper)
				nand_gate_out = up_rd[0];
			if (comb_ok)
			begin
				// Results of both halves stay on their pins
				if (combine_sel == `LCF_COMB_MUX)
					combine_gate_out = bypass_control_input ?
						up_res : lo_res;
				else
					combine_gate_out = up_res ^ lo_res ^
						bypass_control_input;
				nand_gate_out = ~(up_res & lo_res &
					bypass_control_input);
			end
			quarter_vals = {quarter_out_three, nand_gate_out,
				combine_gate_out, quarter_out_zero};
		end
		// Cell outputs (memory read data, LUT results or ripple sum) may feed the storage elements instead
		storage_data = read_to_storage ? quarter_vals :
			direct_write_bits;
	end

	// ------------------------------------------------------------
	// Table write
	// ------------------------------------------------------------
	// Clocked write stands in for the pulse, data lands on the edge
	always @*
	begin
		table_next = table_reg;
		if (cfg_load)
			table_next = cfg_table;
		else
		begin
			if (we_lower)
			begin
				table_next[bit_index(2'h0, second_bus[3:0])] =
					direct_write_bits[0];
				table_next[bit_index(2'h1, second_bus[3:0])] =
					direct_write_bits[1];
			end
			if (we_upper)
			begin
				table_next[bit_index(2'h2, first_bus[3:0])] =
					direct_write_bits[2];
				table_next[bit_index(2'h3, first_bus[3:0])] =
					direct_write_bits[3];
			end
		end
	end

	always @(posedge sys_clk)
	begin
		// Enable low freezes the table, reset included
		if (clk_en)
		begin
			if (rst)
				table_reg <= `LCF_TABLE_RESET;
			else
				table_reg <= table_next;
		end
	end

endmodule

// [inc/lcf_consts.vh]
// Purpose: Constants for the logic cell function unit
// Assumes: Included by core/lcf_unit.v only
// Notes: Mode and select encodings are local choices
`ifndef LCF_CONSTS_VH
`define LCF_CONSTS_VH

// ------------------------------------------------------------
// Table geometry
// ------------------------------------------------------------
`define LCF_TABLE_BITS 64
`define LCF_QUARTER_BITS 16
`define LCF_HALF_BITS 32
`define LCF_WORDS 16

// ------------------------------------------------------------
// Operating mode, one per bit
// ------------------------------------------------------------
`define LCF_MODE_W 3
`define LCF_MODE_LOGIC 3'h1
`define LCF_MODE_RIPPLE 3'h2
`define LCF_MODE_MEMORY 3'h4

// ------------------------------------------------------------
// Combining gate select
// ------------------------------------------------------------
`define LCF_COMB_NONE 2'h0
`define LCF_COMB_MUX 2'h1
`define LCF_COMB_XOR 2'h2

// ------------------------------------------------------------
// Ripple submodes
// ------------------------------------------------------------
`define LCF_SUB_ADDSUB 2'h0
`define LCF_SUB_COUNT 2'h1
`define LCF_SUB_MULT 2'h2
`define LCF_SUB_EQUAL 2'h3

// ------------------------------------------------------------
// Ripple-in source
// ------------------------------------------------------------
`define LCF_CIN_FAST 2'h0
`define LCF_CIN_BUS 2'h1
`define LCF_CIN_ONE 2'h2
`define LCF_CIN_ZERO 2'h3

// ------------------------------------------------------------
// Carry-out routing, one bit each
// ------------------------------------------------------------
`define LCF_RIPPLE_OUT_PORT_FAST_BIT 0
`define LCF_RIPPLE_OUT_PORT_PIN_BIT 1

// ------------------------------------------------------------
// Reset value and count step
// ------------------------------------------------------------
`define LCF_TABLE_RESET 64'h0
`define LCF_COUNT_STEP 4'h1

`endif

// [testbench/lcf_monitor.sv]
// Purpose: Port checker for lcf_unit
// Assumes: Bound to every lcf_unit instance
// Notes: Memory hold is checked only where no write can land
`timescale 1ns/100ps
module lcf_monitor
(
	// Control
	input wire sys_clk,
	input wire rst,
	input wire clk_en,
	input wire [2:0] half_mode_upper,
	input wire [2:0] half_mode_lower,
	input wire [1:0] combine_sel,
	input wire [1:0] ripple_submode,
	input wire [1:0] ripple_out_port_route,
	input wire wpe_from_ripple_in,
	input wire cfg_load,
	// Cell
	input wire [4:0] first_bus,
	input wire [4:0] second_bus,
	input wire bypass_control_input,
	input wire quarter_out_zero,
	input wire combine_gate_out,
	input wire nand_gate_out,
	input wire quarter_out_three,
	input wire ripple_out_port,
	input wire mode_error
);
	wire lg = half_mode_upper == 3'h1 && half_mode_lower == 3'h1;
	wire rp = half_mode_upper == 3'h2 && half_mode_lower == 3'h2;
	wire mm = half_mode_upper == 3'h4 && half_mode_lower == 3'h4;
	wire u = quarter_out_three;
	wire l = quarter_out_zero;
	wire b = bypass_control_input;
	wire [3:0] a = first_bus[3:0];
	wire [3:0] q = {u, nand_gate_out, combine_gate_out, l};
	wire quiet = !cfg_load && (!clk_en || (!wpe_from_ripple_in && !b));
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_mux_select: assert property (lg && combine_sel == 2'h1 |->
		combine_gate_out == (b ? u : l)) else $error("mux out");
	a_xor_combine: assert property (lg && combine_sel == 2'h2 |->
		combine_gate_out == (u ^ l ^ b)) else $error("xor out");
	a_nand_gate: assert property (lg && ^combine_sel |->
		nand_gate_out == !(u && l && b)) else $error("nand out");
	a_bad_combine: assert property (combine_sel == 2'h3 |-> mode_error)
		else $error("combine flag");
	a_ripple_mixed: assert property
		((half_mode_upper == 3'h2) != (half_mode_lower == 3'h2) |-> mode_error)
		else $error("mixed flag");
	a_equal_carry: assert property (rp && ripple_submode == 2'h3 |->
		ripple_out_port == (ripple_out_port_route[0] && a != second_bus[3:0]))
		else $error("equal carry");
	a_count_step: assert property (rp && ripple_submode == 2'h1 |->
		q == (first_bus[4] ? a + 4'h1 : a - 4'h1)) else $error("count");
	a_mem_hold: assert property (mm && quiet ##1 mm &&
		$stable(a) && $stable(second_bus[3:0]) |-> $stable(u) && $stable(l))
		else $error("memory changed");
endmodule
bind lcf_unit lcf_monitor lcf_monitor_inst (.sys_clk, .rst, .clk_en,
	.half_mode_upper, .half_mode_lower, .combine_sel, .ripple_submode,
	.ripple_out_port_route, .wpe_from_ripple_in, .cfg_load, .first_bus, .second_bus,
	.bypass_control_input, .quarter_out_zero, .combine_gate_out,
	.nand_gate_out, .quarter_out_three, .ripple_out_port, .mode_error);

// [testbench/lcf_neighbour.sv]
// Purpose: Neighbouring cells: carry source and bank decode
// Assumes: Operands driven by the bench
// Notes: Decode feeds the write gate while wpe_from_ripple_in is low, so only one bank writes
`timescale 1ns/100ps
module lcf_neighbour
#(
	parameter BANK = 2'h1
)
(
	input wire [3:0] nb_a,
	input wire [3:0] nb_b,
	output wire carry_out,
	input wire [1:0] addr_hi,
	output wire bank_en
);
	assign carry_out = {1'h0, nb_a} + {1'h0, nb_b} > 5'h0f;
	assign bank_en = addr_hi == BANK;
endmodule

// [testbench/test_logic_cell_lut_function_unit.sv]
// Purpose: Self-checking bench for lcf_unit
// Assumes: Monitor and neighbour compiled first
// Notes: Model keeps its own copy of the table
`timescale 1ns/100ps
module test_logic_cell_lut_function_unit;
	reg sys_clk = 1'h0, rst = 1'h1, clk_en = 1'h1, wpe_from_ripple_in = 1'h0;
	reg read_to_storage = 1'h0, cfg_load = 1'h0, byp = 1'h0, bank = 1'h0;
	reg [2:0] half_mode_upper = 3'h1, half_mode_lower = 3'h1;
	reg [1:0] combine_sel = 2'h0, ripple_submode = 2'h0, ripple_in_sel = 2'h0;
	reg [1:0] ripple_out_port_route = 2'h0, addr_hi = 2'h0;
	reg [3:0] nb_a = 4'h0, nb_b = 4'h0, direct_write_bits = 4'h0;
	reg [4:0] first_bus = 5'h0, second_bus = 5'h0;
	reg [63:0] cfg_table = 64'h0, tbl = 64'h0;
	integer err_count = 0, compares = 0, cyc = 0, i, r, ci, ua, la, u, l;
	wire bypass_control_input, fast_carry_in, bank_en, fifth_cell_output;
	wire quarter_out_zero, combine_gate_out, nand_gate_out, quarter_out_three;
	wire ripple_out_port, mode_error;
	wire [3:0] storage_data;
	wire [3:0] q = {quarter_out_three, nand_gate_out, combine_gate_out,
		quarter_out_zero};
	assign bypass_control_input = bank ? bank_en : byp;
	lcf_neighbour lcf_neighbour_inst (.nb_a, .nb_b, .carry_out(fast_carry_in),
		.addr_hi, .bank_en);
	lcf_unit lcf_unit_inst (.sys_clk, .rst, .clk_en, .half_mode_upper,
		.half_mode_lower, .combine_sel, .ripple_submode, .ripple_in_sel,
		.ripple_out_port_route, .wpe_from_ripple_in, .read_to_storage, .cfg_load,
		.cfg_table, .first_bus, .second_bus, .bypass_control_input,
		.fast_carry_in, .direct_write_bits, .quarter_out_zero,
		.combine_gate_out, .nand_gate_out, .quarter_out_three,
		.fifth_cell_output, .ripple_out_port, .storage_data, .mode_error);
	initial
		forever #5 sys_clk = ~sys_clk;
	task chk(input [3:0] got, input [3:0] exp);
	begin
		compares = compares + 1;
		if (got !== exp)
		begin
			err_count = err_count + 1;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	end
	endtask
	task conclude;
	begin
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	// Hang guard well above the roughly 850 cycles used
	always @(posedge sys_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 4000)
		begin
			err_count = err_count + 1;
			conclude;
		end
	end
	function integer cin_of(input [1:0] s);
		cin_of = s == 2'h0 ? {1'h0, nb_a} + nb_b > 5'h0f :
			s == 2'h1 ? second_bus[4] : s == 2'h2;
	endfunction
	task mem_run(input integer n);
	begin
		half_mode_upper = 3'h4;
		bank = 1'h1;
		for (i = 0; i < n; i = i + 1)
		begin
			half_mode_lower = i[2] ? 3'h4 : 3'h1;
			if (!i[0])
				{first_bus, second_bus} = $urandom;
			{direct_write_bits, clk_en, addr_hi, wpe_from_ripple_in} = $urandom;
			{ripple_in_sel, read_to_storage, nb_a, nb_b} = $urandom;
			#1;
			ua = first_bus[3:0];
			la = second_bus[3:0];
			l = i[2] ? tbl[la] : tbl[second_bus];
			chk(quarter_out_three, tbl[48 + ua]);
			chk(nand_gate_out, tbl[32 + ua]);
			chk(quarter_out_zero, l);
			r = {tbl[48 + ua], tbl[32 + ua], tbl[16 + la], l[0]};
			if (i[2])
				chk(q, r);
			if (i[2] || !read_to_storage)
				chk(storage_data, read_to_storage ? r : direct_write_bits);
			u = clk_en && (wpe_from_ripple_in ? cin_of(ripple_in_sel) :
				addr_hi == 2'h1);
			@(posedge sys_clk);
			if (u && first_bus[4])
				{tbl[48 + ua], tbl[32 + ua]} = direct_write_bits[3:2];
			if (u && i[2] && second_bus[4])
				{tbl[16 + la], tbl[la]} = direct_write_bits[1:0];
			@(negedge sys_clk);
		end
	end
	endtask
	initial
	begin
		i = $urandom(32'h0333);
		repeat (3) @(negedge sys_clk);
		rst = 1'h0;
		cfg_table = {$urandom, $urandom};
		cfg_load = 1'h1;
		@(negedge sys_clk);
		cfg_load = 1'h0;
		tbl = cfg_table;
		for (i = 0; i < 200; i = i + 1)
		begin
			first_bus = $urandom;
			second_bus = i[0] ? first_bus : $urandom;
			byp = $urandom;
			combine_sel = i[1] ? 2'h2 : 2'h1;
			#1;
			u = tbl[32 + first_bus];
			l = tbl[second_bus];
			chk(quarter_out_three, u);
			chk(quarter_out_zero, l);
			chk(combine_gate_out, i[1] ? u ^ l ^ byp : byp ? u : l);
			chk(nand_gate_out, !(u && l && byp));
			chk(mode_error, 1'h0);
			@(negedge sys_clk);
		end
		combine_sel = 2'h3;
		#1 chk(mode_error, 1'h1);
		@(negedge sys_clk);
		$display("logic test done");
		combine_sel = 2'h0;
		{half_mode_upper, half_mode_lower} = {3'h2, 3'h2};
		for (i = 0; i < 300; i = i + 1)
		begin
			{first_bus, second_bus} = $urandom;
			{ripple_submode, ripple_in_sel, ripple_out_port_route, nb_a, nb_b} = $urandom;
			#1;
			ua = first_bus[3:0];
			la = second_bus[3:0];
			ci = cin_of(ripple_in_sel);
			case (ripple_submode)
			2'h0: r = ua + (first_bus[4] ? la : 4'hf - la) + ci;
			2'h1: r = first_bus[4] ? ua + 4'h1 : ua - 4'h1;
			2'h2: r = ua + (first_bus[4] ? la : 4'h0) + ci;
			default: r = ua != la ? 5'h10 : 5'h0;
			endcase
			chk(mode_error, 1'h0);
			if (ripple_submode != 2'h3)
				chk(q, r);
			if (ripple_submode != 2'h1)
			begin
				chk(ripple_out_port, ripple_out_port_route[0] & r[4]);
				chk(fifth_cell_output, ripple_out_port_route[1] & r[4]);
			end
			@(negedge sys_clk);
		end
		half_mode_lower = 3'h1;
		#1 chk(mode_error, 1'h1);
		@(negedge sys_clk);
		$display("ripple test done");
		mem_run(300);
		rst = 1'h1;
		clk_en = 1'h1;
		@(negedge sys_clk);
		rst = 1'h0;
		tbl = 64'h0;
		mem_run(40);
		$display("memory test done");
		conclude;
	end
endmodule
